// *** rtl/pimw_pkg.sv ***
/*
  package of the process image word mapper: image layout, word offsets,
  module layout kinds and the structs that carry the controller port and the
  module-side data. assumes one node with fixed slots as laid out below.
*/
package pimw_pkg;

  localparam int unsigned W_WORD    = 16;
  localparam int unsigned W_ADDR    = 4;
  localparam int unsigned N_AO      = 4;    // analog output channels
  localparam int unsigned N_AI      = 2;    // analog input channels
  localparam int unsigned N_SPEC    = 4;    // words reserved for the specialty slot

  // output image: analog words first, then digital, then specialty
  localparam logic [3:0] OUT_AO_BASE   = 4'h0;
  localparam logic [3:0] OUT_DO_WORD   = 4'h4;
  localparam logic [3:0] OUT_SPEC_BASE = 4'h5;
  localparam logic [3:0] OUT_WORDS     = 4'h9;
  // input image: analog words first, then digital, then specialty
  localparam logic [3:0] IN_AI_BASE    = 4'h0;
  localparam logic [3:0] IN_DI_WORD    = 4'h2;
  localparam logic [3:0] IN_SPEC_BASE  = 4'h3;
  localparam logic [3:0] IN_WORDS      = 4'h7;

  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  // byte lane masks: bit 0 low byte, bit 1 high byte
  localparam logic [1:0]  LANE_NONE    = 2'h0;
  localparam logic [1:0]  LANE_LOW     = 2'h1;
  localparam logic [1:0]  LANE_BOTH    = 2'h3;

  typedef enum logic [2:0] {
    PIMW_CNT32,       // one 32-bit counter, one control/status byte
    PIMW_DUAL_SHARED, // two 16-bit counters, one shared byte
    PIMW_DUAL_SPLIT,  // two 16-bit counters, a byte each
    PIMW_PWM,         // two pulse width channels, a byte each
    PIMW_SER_ALT      // serial interface, alternative format
  } pimw_kind_t;

  typedef enum logic {
    PIMW_IMG_IN,
    PIMW_IMG_OUT
  } pimw_img_t;

  typedef struct packed {
    logic              req;    // access strobe
    logic              we;     // write when high
    pimw_img_t         img;    // image selected
    logic [W_ADDR-1:0] addr;   // word offset
    logic [W_WORD-1:0] wdata;  // write word
  } pimw_req_t;

  typedef struct packed {
    logic              valid;  // one cycle after req
    logic [W_WORD-1:0] rdata;  // read word, zero after writes
  } pimw_rsp_t;

  typedef struct packed {
    logic [N_AO-1:0][W_WORD-1:0] ao;          // analog output values
    logic [7:0]                  dout;        // digital output byte
    logic [7:0]                  first_counter_ctrl;
    logic [7:0]                  second_counter_ctrl;
    logic                        first_ctrl_wr;  // controller wrote byte
    logic                        second_ctrl_wr;
    logic [31:0]                 setting;     // setting / data value
  } pimw_mod_out_t;

  typedef struct packed {
    logic [N_AI-1:0][W_WORD-1:0] ai;          // analog input values
    logic [7:0]                  din;         // digital input byte
    logic [7:0]                  first_counter_stat;
    logic [7:0]                  second_counter_stat;
    logic [31:0]                 value;       // counter / data value
  } pimw_mod_in_t;

endpackage

// *** rtl/pimw_mapper.sv ***
/*
  process image word mapper: holds the output image, builds the input image
  from module data, and serves whole-word reads and writes from the node
  controller. assumes the controller side is synchronous to mclk and that the
  modules accept new values every cycle.
*/
// How it works
// - analog output channel is little-endian word
// - analog module status bits never reach controller
// - analog output words precede digital output
// - two channels map to words 0,1
// - channel n at word n-1, up to 3
// - control/status byte always in low byte
// - control bytes go out, status bytes come in
// - control and data stored apart from status
// - 32-bit counter spans three words
// - dual counters share byte in word 0
// - split counters use four words
// - pulse width uses four words, bytes 0,4
// - serial alt: handshake low, data bytes packed
// - specialty image word aligned, whole words
// - analog input words precede digital input
`timescale 1ns/1ps

module pimw_mapper (
  input  wire logic                 mclk,     // 100 MHz clock
  input  wire logic                 arst_n,   // async reset, low active
  input  pimw_pkg::pimw_kind_t      kind,     // specialty layout in slot
  input  pimw_pkg::pimw_req_t       ctl_req,  // controller access
  output pimw_pkg::pimw_rsp_t       ctl_rsp,  // controller answer
  input  pimw_pkg::pimw_mod_in_t    mod_in,   // data from modules
  output pimw_pkg::pimw_mod_out_t   mod_out   // data to modules
);
  import pimw_pkg::*;

  // which byte lanes of specialty word w hold data for a layout
  function automatic logic [1:0] lanes(pimw_kind_t k, logic [1:0] w);
    logic [1:0] m;
    m = LANE_NONE;
    case (k)
      PIMW_CNT32, PIMW_DUAL_SHARED: begin
        m = (w == 2'd0) ? LANE_LOW : (w == 2'd3) ? LANE_NONE : LANE_BOTH;
      end
      PIMW_DUAL_SPLIT, PIMW_PWM: begin
        m = w[0] ? LANE_BOTH : LANE_LOW;
      end
      PIMW_SER_ALT: begin
        m = w[1] ? LANE_NONE : LANE_BOTH;
      end
      default: m = LANE_NONE;
    endcase
    return m;
  endfunction

  // clear the lanes that a layout leaves unused
  function automatic logic [15:0] masked(logic [1:0] m, logic [15:0] v);
    return {m[1] ? v[15:8] : BYTE_ZERO, m[0] ? v[7:0] : BYTE_ZERO};
  endfunction

  // true when a layout has a second control/status byte in word 2
  function automatic logic split_bytes(pimw_kind_t k);
    return (k == PIMW_DUAL_SPLIT) || (k == PIMW_PWM);
  endfunction

  logic                     rst_s1_q;
  logic                     rst_n_q;
  logic [W_WORD-1:0]        oimg_q [OUT_WORDS];
  logic [W_WORD-1:0]        iword;
  logic [W_WORD-1:0]        oword;
  logic [W_WORD-1:0]        spec_in [N_SPEC];
  pimw_rsp_t                rsp_q;
  pimw_mod_out_t            out_q;
  logic                     wr_out;
  logic [1:0]               wr_spec_w;
  logic                     wr_spec;
  logic                     first_wr_q;
  logic                     second_wr_q;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // decode of a write into the output image
  assign wr_out    = ctl_req.req && ctl_req.we && (ctl_req.img == PIMW_IMG_OUT)
                     && (ctl_req.addr < OUT_WORDS);
  assign wr_spec   = wr_out && (ctl_req.addr >= OUT_SPEC_BASE);
  assign wr_spec_w = 2'(ctl_req.addr - OUT_SPEC_BASE);

  // output image storage, kept apart from what the modules report
  // control store
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < int'(OUT_WORDS); i++) begin
        oimg_q[i] <= WORD_ZERO;
      end
    end else if (wr_out) begin
      if (wr_spec) begin
        oimg_q[ctl_req.addr] <= masked(lanes(kind, wr_spec_w), ctl_req.wdata);
      end else if (ctl_req.addr == OUT_DO_WORD) begin
        // digital data is grouped in bytes after the analog words
        oimg_q[ctl_req.addr] <= {BYTE_ZERO, ctl_req.wdata[7:0]};
      end else begin
        oimg_q[ctl_req.addr] <= ctl_req.wdata;
      end
    end
  end

  // specialty input words built from module status and values
  always_comb begin
    for (int i = 0; i < int'(N_SPEC); i++) begin
      spec_in[i] = WORD_ZERO;
    end
    case (kind)
      // one byte, value low word, value high word
      PIMW_CNT32, PIMW_DUAL_SHARED: begin
        spec_in[0] = {BYTE_ZERO, mod_in.first_counter_stat};
        spec_in[1] = mod_in.value[15:0];
        spec_in[2] = mod_in.value[31:16];
      end
      PIMW_DUAL_SPLIT, PIMW_PWM: begin
        spec_in[0] = {BYTE_ZERO, mod_in.first_counter_stat};
        spec_in[1] = mod_in.value[15:0];
        spec_in[2] = {BYTE_ZERO, mod_in.second_counter_stat};
        spec_in[3] = mod_in.value[31:16];
      end
      PIMW_SER_ALT: begin
        spec_in[0] = {mod_in.value[7:0], mod_in.first_counter_stat};
        spec_in[1] = mod_in.value[23:8];
      end
      default: begin
        spec_in[0] = WORD_ZERO;
      end
    endcase
  end

  // input image word at the requested offset
  // analog inputs first
  always_comb begin
    iword = WORD_ZERO;
    if (ctl_req.addr < IN_DI_WORD) begin
      iword = mod_in.ai[1'(ctl_req.addr - IN_AI_BASE)];
    end else if (ctl_req.addr == IN_DI_WORD) begin
      iword = {BYTE_ZERO, mod_in.din};
    end else if (ctl_req.addr < IN_WORDS) begin
      iword = spec_in[2'(ctl_req.addr - IN_SPEC_BASE)];
    end else begin
      iword = WORD_ZERO;
    end
  end

  // output image readback; unmapped offsets read zero
  always_comb begin
    oword = WORD_ZERO;
    if (ctl_req.addr < OUT_WORDS) begin
      oword = oimg_q[ctl_req.addr];
    end
  end

  // control write events held one stage, since the byte reaches the
  // module one edge after the image store; the pulse must not lead it
  // pulse meets byte
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      first_wr_q  <= 1'b0;
      second_wr_q <= 1'b0;
    end else begin
      first_wr_q  <= wr_spec && (wr_spec_w == 2'd0);
      second_wr_q <= wr_spec && (wr_spec_w == 2'd2) && split_bytes(kind);
    end
  end

  // registered answer, one cycle after the request
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= ctl_req.req;
      if (ctl_req.req && !ctl_req.we) begin
        rsp_q.rdata <= (ctl_req.img == PIMW_IMG_OUT) ? oword : iword;
      end else begin
        rsp_q.rdata <= WORD_ZERO;
      end
    end
  end

  // module-side outputs taken from the image every cycle
  // only values leave, no status path
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < int'(N_AO); i++) begin
        out_q.ao[i] <= oimg_q[int'(OUT_AO_BASE) + i];
      end
      out_q.dout <= oimg_q[OUT_DO_WORD][7:0];
      out_q.first_counter_ctrl  <= oimg_q[OUT_SPEC_BASE][7:0];
      out_q.second_counter_ctrl <= split_bytes(kind) ? oimg_q[OUT_SPEC_BASE + 4'h2][7:0]
                                                     : BYTE_ZERO;
      // write of a control byte is an event
      out_q.first_ctrl_wr  <= first_wr_q;
      out_q.second_ctrl_wr <= second_wr_q;
      case (kind)
        PIMW_CNT32, PIMW_DUAL_SHARED: begin
          out_q.setting <= {oimg_q[OUT_SPEC_BASE + 4'h2], oimg_q[OUT_SPEC_BASE + 4'h1]};
        end
        PIMW_DUAL_SPLIT, PIMW_PWM: begin
          out_q.setting <= {oimg_q[OUT_SPEC_BASE + 4'h3], oimg_q[OUT_SPEC_BASE + 4'h1]};
        end
        PIMW_SER_ALT: begin
          out_q.setting <= {BYTE_ZERO, oimg_q[OUT_SPEC_BASE + 4'h1],
                            oimg_q[OUT_SPEC_BASE][15:8]};
        end
        default: out_q.setting <= '0;
      endcase
    end
  end

  assign ctl_rsp = rsp_q;
  assign mod_out = out_q;

endmodule

// *** verif/pimw_mapper_sva.sv ***
/*
  checker of the word mapper ports: answer timing, word placement, refusals.
  assumes requests start only after the internal reset has ended.
*/
`timescale 1ns/1ps
module pimw_mapper_chk
  import pimw_pkg::*;
(
  input wire logic                mclk,     // clock
  input wire logic                arst_n,   // async reset, low active
  input pimw_pkg::pimw_kind_t     kind,     // slot layout
  input pimw_pkg::pimw_req_t      ctl_req,  // controller request
  input pimw_pkg::pimw_rsp_t      ctl_rsp,  // controller answer
  input pimw_pkg::pimw_mod_in_t   mod_in,   // module data
  input pimw_pkg::pimw_mod_out_t  mod_out   // data to modules
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // request kinds
  wire logic wr_o = ctl_req.req && ctl_req.we && ctl_req.img == PIMW_IMG_OUT;
  wire logic rd_i = ctl_req.req && !ctl_req.we && ctl_req.img == PIMW_IMG_IN;

  a_valid_after_req: assert property (ctl_req.req |=> ctl_rsp.valid)
    else $error("no answer");
  a_no_stray_valid: assert property (!ctl_req.req |=> !ctl_rsp.valid)
    else $error("stray answer");
  a_ao_word_le: assert property (wr_o && ctl_req.addr < 4 |-> ##2
    mod_out.ao[$past(ctl_req.addr[1:0], 2)] == $past(ctl_req.wdata, 2)) else $error("ao word");
  a_do_after_ao: assert property (wr_o && ctl_req.addr == OUT_DO_WORD |-> ##2
    mod_out.dout == $past(ctl_req.wdata[7:0], 2)) else $error("do byte");
  a_ctrl_low_byte: assert property (wr_o && ctl_req.addr == OUT_SPEC_BASE |-> ##2
    mod_out.first_ctrl_wr && mod_out.first_counter_ctrl == $past(ctl_req.wdata[7:0], 2))
    else $error("ctrl byte");
  a_second_ctrl_pulse: assert property (wr_o && ctl_req.addr == OUT_SPEC_BASE + 4'h2 &&
    kind inside {PIMW_DUAL_SPLIT, PIMW_PWM} |-> ##2 mod_out.second_ctrl_wr &&
    mod_out.second_counter_ctrl == $past(ctl_req.wdata[7:0], 2)) else $error("second pulse");
  a_second_refused: assert property (!(kind inside {PIMW_DUAL_SPLIT, PIMW_PWM}) |->
    !mod_out.second_ctrl_wr) else $error("second ctrl");
  a_stat_low_byte: assert property (rd_i && ctl_req.addr == IN_SPEC_BASE &&
    kind != PIMW_SER_ALT |=> ctl_rsp.rdata == {BYTE_ZERO, $past(mod_in.first_counter_stat)})
    else $error("stat byte");
  a_ai_word_read: assert property (rd_i && ctl_req.addr < 2 |=>
    ctl_rsp.rdata == mod_in.ai[$past(ctl_req.addr[0])]) else $error("ai word");
  a_unmapped_zero: assert property (rd_i && ctl_req.addr >= IN_WORDS |=>
    ctl_rsp.rdata == WORD_ZERO) else $error("unmapped read");

  c_ctrl_write: cover property (wr_o && ctl_req.addr == OUT_SPEC_BASE);
  c_ser_read: cover property (rd_i && kind == PIMW_SER_ALT);
  c_second_ctrl: cover property (mod_out.second_ctrl_wr);
endmodule

bind pimw_mapper pimw_mapper_chk chk_u (.mclk, .arst_n, .kind, .ctl_req, .ctl_rsp, .mod_in,
  .mod_out);

// *** verif/pimw_io_model.sv ***
/*
  model of the i/o modules behind the mapper: steady module-side levels.
  assumes the mapper samples them only on reads, so no timing is needed.
*/
`timescale 1ns/1ps
module pimw_io_model
  import pimw_pkg::*;
(
  output pimw_pkg::pimw_mod_in_t mod_in  // values to the mapper
);
  // fixed levels keep expectations plain; byte halves differ to expose swaps
  assign mod_in = {16'h2b1c, 16'h9e07, 8'h69, 8'h5a, 8'h3c, 32'h89abcdef};
endmodule

// *** verif/test_pimw_mapper.sv ***
/*
  testbench of the word mapper: the bench plays the node controller.
  assumes the io model levels and the slot offsets of the package.
*/
`timescale 1ns/1ps
module test_pimw_mapper;
  import pimw_pkg::*;
  logic          mclk = 1'b0;
  logic          arst_n = 1'b0;
  pimw_kind_t    kind = PIMW_CNT32;
  pimw_req_t     ctl_req = '0;
  pimw_rsp_t     ctl_rsp;
  pimw_mod_in_t  mod_in;
  pimw_mod_out_t mod_out;
  int            errors = 0;
  int            tests_run = 0;
  int            cyc = 0;

  pimw_mapper dut_u (.mclk, .arst_n, .kind, .ctl_req, .ctl_rsp, .mod_in, .mod_out);
  pimw_io_model io_u (.mod_in);

  // clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one access, request held up; answer stands in the cycle after the edge
  task automatic acc(input logic we, input pimw_img_t img, input logic [3:0] a,
                     input logic [15:0] wd, input logic [15:0] exp);
    ctl_req <= '{req: 1'b1, we: we, img: img, addr: a, wdata: wd};
    @(negedge mclk);
    chk({15'h0, ctl_rsp.valid, ctl_rsp.rdata}, {16'h0001, we ? 16'h0000 : exp});
  endtask

  task automatic idle;
    ctl_req.req <= 1'b0;
    @(negedge mclk);
  endtask

  // analog words back to back, then the digital byte with its high byte dropped
  task automatic t_out_map;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, PIMW_IMG_OUT, 4'(i), 16'ha5c0 + 16'(i), 16'h0);
    end
    acc(1'b1, PIMW_IMG_OUT, OUT_DO_WORD, 16'h7e96, 16'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, PIMW_IMG_OUT, 4'(i), 16'h0, 16'ha5c0 + 16'(i));
      chk(32'(mod_out.ao[i]), 32'ha5c0 + 32'(i));
    end
    acc(1'b0, PIMW_IMG_OUT, OUT_DO_WORD, 16'h0, 16'h0096);
    chk(32'(mod_out.dout), 32'h96);
    idle();
  endtask

  // input map, writes into the input image, offsets past the end
  task automatic t_in_map;
    acc(1'b0, PIMW_IMG_IN, IN_AI_BASE, 16'h0, 16'h9e07);
    acc(1'b0, PIMW_IMG_IN, 4'h1, 16'h0, 16'h2b1c);
    acc(1'b0, PIMW_IMG_IN, IN_DI_WORD, 16'h0, 16'h0069);
    acc(1'b1, PIMW_IMG_IN, IN_AI_BASE, 16'hffff, 16'h0);
    acc(1'b0, PIMW_IMG_IN, IN_AI_BASE, 16'h0, 16'h9e07);
    acc(1'b1, PIMW_IMG_OUT, OUT_WORDS, 16'hffff, 16'h0);
    acc(1'b0, PIMW_IMG_OUT, OUT_WORDS, 16'h0, 16'h0);
    acc(1'b0, PIMW_IMG_IN, IN_WORDS, 16'h0, 16'h0);
    idle();
  endtask

  // every specialty layout, both directions
  task automatic t_spec;
    logic sa;
    logic sp;
    for (int n = 0; n < 5; n++) begin
      kind <= pimw_kind_t'(n);
      sa = (n == int'(PIMW_SER_ALT));
      sp = (n == int'(PIMW_DUAL_SPLIT)) || (n == int'(PIMW_PWM));
      @(negedge mclk);
      acc(1'b1, PIMW_IMG_OUT, OUT_SPEC_BASE, 16'hc1a5, 16'h0);
      acc(1'b1, PIMW_IMG_OUT, 4'h6, 16'h3344, 16'h0);
      acc(1'b1, PIMW_IMG_OUT, 4'h7, 16'h5566, 16'h0);
      acc(1'b1, PIMW_IMG_OUT, 4'h8, 16'h7788, 16'h0);
      acc(1'b0, PIMW_IMG_OUT, OUT_SPEC_BASE, 16'h0, sa ? 16'hc1a5 : 16'h00a5);
      chk(mod_out.setting, sa ? 32'h003344c1 : sp ? 32'h77883344 : 32'h55663344);
      chk({mod_out.first_counter_ctrl, mod_out.second_counter_ctrl}, {8'ha5, sp ? 8'h66 : 8'h00});
      acc(1'b0, PIMW_IMG_IN, IN_SPEC_BASE, 16'h0, sa ? 16'hef5a : 16'h005a);
      acc(1'b0, PIMW_IMG_IN, 4'h4, 16'h0, sa ? 16'habcd : 16'hcdef);
      acc(1'b0, PIMW_IMG_IN, 4'h5, 16'h0, sa ? 16'h0 : sp ? 16'h003c : 16'h89ab);
      acc(1'b0, PIMW_IMG_IN, 4'h6, 16'h0, sp ? 16'h89ab : 16'h0);
      idle();
    end
  endtask

  task automatic results;
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 80 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      results();
    end
  end

  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(negedge mclk);
    t_out_map();
    t_in_map();
    t_spec();
    results();
  end
endmodule
